// ---- core/iocr_pkg.sv ----
// constants, encodings and types of the i/o register command responder
// assumes one 25 MHz clock and a synchronous active-high reset
package iocr_pkg;

  // ****************************************
  // command and error codes
  // ****************************************
  localparam logic [7:0] CMD_RD_COIL   = 8'h01;
  localparam logic [7:0] CMD_RD_HOLD   = 8'h03;
  localparam logic [7:0] CMD_RD_INPUT  = 8'h04;
  localparam logic [7:0] CMD_WR_COIL   = 8'h0F;
  localparam logic [7:0] CMD_WR_HOLD   = 8'h10;
  localparam logic [7:0] ERR_FLAG      = 8'h80;
  localparam logic [7:0] EXC_NONE      = 8'h00;
  localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0] EXC_ILL_VALUE = 8'h03;
  localparam logic [7:0] EXC_DEV_FAIL  = 8'h04;

  // ****************************************
  // frame layout, byte positions from zero
  // ****************************************
  localparam logic [7:0]  POS_CMD       = 8'h00;
  localparam logic [7:0]  POS_ADDR_HI   = 8'h01;
  localparam logic [7:0]  POS_ADDR_LO   = 8'h02;
  localparam logic [7:0]  POS_CNT_HI    = 8'h03;
  localparam logic [7:0]  POS_CNT_LO    = 8'h04;
  localparam logic [7:0]  POS_BCNT      = 8'h05;
  localparam logic [7:0]  GET_FRAME_LEN = 8'h05;
  localparam logic [7:0]  SET_HDR_LEN   = 8'h06;
  localparam int          RSP_DATA_POS  = 2;
  localparam int          ERR_RSP_LEN   = 2;
  localparam int          SET_RSP_LEN   = 5;
  localparam logic [16:0] ADDR_LIMIT    = 17'h10000;

  // ****************************************
  // trap numbering
  // ****************************************
  localparam int TRAP_COUNT      = 18;
  localparam int NUM_PINS        = 3;
  localparam int NUM_LEVELS      = 5;
  localparam int TRAP_CLEAR_BASE = 9;

  typedef enum logic [1:0] {
    KIND_COIL  = 2'b00,
    KIND_HOLD  = 2'b01,
    KIND_INPUT = 2'b10
  } iocr_kind_t;

  typedef enum logic [2:0] {
    ST_RECV   = 3'b000,
    ST_CHECK  = 3'b001,
    ST_ISSUE  = 3'b010,
    ST_WAIT   = 3'b011,
    ST_HDR    = 3'b100,
    ST_LAUNCH = 3'b101,
    ST_SEND   = 3'b110
  } iocr_state_t;

endpackage

// ---- core/iocr_rsp_buf.sv ----
// response byte buffer: filled by index, then sent as a stream
// assumes no write lands while a response is being sent
`timescale 1ns/10ps
module iocr_rsp_buf #(
  parameter int DEPTH = 64,
  parameter int IDX_W = 6
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             sys_rst_i,
  // fill port, two bytes go high byte first
  input  wire logic             wr_en_i,
  input  wire logic             wr_two_i,
  input  wire logic [IDX_W-1:0] wr_idx_i,
  input  wire logic [15:0]      wr_data_i,
  // send control
  input  wire logic             start_i,
  input  wire logic [IDX_W-1:0] len_i,
  output logic                  busy_o,
  // byte stream out
  input  wire logic             tx_ready_i,
  output logic                  tx_valid_o,
  output logic [7:0]            tx_data_o
);

  if (DEPTH < 6 || DEPTH > (1 << IDX_W))
  begin : g_chk
    $error("response buffer depth does not fit the index");
  end

  logic [7:0]       mem [DEPTH];
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] remain;

  wire [IDX_W-1:0] wr_idx_lo = wr_idx_i + 1'b1;

  always_ff @(posedge ref_clk_i)
  begin
    if (wr_en_i && wr_two_i)
    begin
      mem[wr_idx_i]  <= wr_data_i[15:8];
      mem[wr_idx_lo] <= wr_data_i[7:0];
    end
    else if (wr_en_i)
      mem[wr_idx_i] <= wr_data_i[7:0];
  end

  assign busy_o = tx_valid_o;

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_valid_o <= 1'b0;
      tx_data_o  <= 8'h00;
      rd_idx     <= '0;
      remain     <= '0;
    end
    else if (start_i)
    begin
      tx_valid_o <= 1'b1;
      tx_data_o  <= mem[0];
      rd_idx     <= IDX_W'(1);
      remain     <= len_i;
    end
    else if (tx_valid_o && tx_ready_i)
    begin
      if (remain == IDX_W'(1))
        tx_valid_o <= 1'b0;
      else
      begin
        tx_data_o <= mem[rd_idx];
        rd_idx    <= rd_idx + 1'b1;
        remain    <= remain - 1'b1;
      end
    end
  end

  a_tx_stall: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (tx_valid_o && tx_ready_i == 1'b0) |=> (tx_valid_o && $stable(tx_data_o)))
    else $error("response byte changed while stalled");

endmodule

// ---- core/iocr_top.sv ----
// command/response engine for i/o channel registers, plus trap encoding
// assumes request frames end with rx_last_i, and a register space that
// answers each access with reg_ack_i, on the same clock or any later one
`timescale 1ns/10ps
module iocr_top #(
  parameter int MAX_DATA = 32,
  parameter int CHAN_W   = 4
) (
  // clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 sys_rst_i,
  // request byte stream
  input  wire logic                 rx_valid_i,
  input  wire logic [7:0]           rx_data_i,
  input  wire logic                 rx_last_i,
  output logic                      rx_ready_o,
  // response byte stream
  input  wire logic                 tx_ready_i,
  output logic                      tx_valid_o,
  output logic [7:0]                tx_data_o,
  // channel register space
  output logic                      reg_req_o,
  output logic                      reg_we_o,
  output iocr_pkg::iocr_kind_t      reg_kind_o,
  output logic [15:0]               reg_addr_o,
  output logic [15:0]               reg_wdata_o,
  input  wire logic                 reg_ack_i,
  input  wire logic [15:0]          reg_rdata_i,
  input  wire logic                 reg_bad_addr_i,
  input  wire logic                 reg_fault_i,
  // alarm events, pins: set ready, carrier, clear to send
  input  wire logic                 sensor_alarm_i,
  input  wire logic [2:0]           pin_alarm_i,
  input  wire logic [4:0]           level_alarm_i,
  input  wire logic                 sensor_clear_i,
  input  wire logic [2:0]           pin_clear_i,
  input  wire logic [4:0]           level_clear_i,
  input  wire logic [CHAN_W-1:0]    alarm_chan_i,
  // trap output
  input  wire logic                 trap_ready_i,
  output logic                      trap_valid_o,
  output logic [4:0]                trap_code_o,
  output logic [CHAN_W-1:0]         trap_chan_o
);
  import iocr_pkg::*;

  localparam int DW = $clog2(MAX_DATA);
  localparam int IW = DW + 1;
  localparam logic [7:0] RX_LIMIT = SET_HDR_LEN + 8'(MAX_DATA);

  if (MAX_DATA < 4 || MAX_DATA > 64 || (1 << DW) != MAX_DATA || CHAN_W < 1)
  begin : g_chk
    $error("MAX_DATA must be a power of two from 4 to 64");
  end

  // ****************************************
  // state
  // ****************************************
  iocr_state_t state;
  iocr_state_t next_state;
  logic [7:0]  rx_idx;
  logic        overflow;
  logic [7:0]  cmd;
  logic [15:0] start_addr;
  logic [15:0] reg_cnt;
  logic [7:0]  byte_cnt;
  logic [7:0]  wmem [MAX_DATA];
  logic [15:0] op_idx;
  logic [7:0]  acc;
  logic        err;
  logic [7:0]  exc;
  logic [1:0]  hdr_step;
  logic        buf_busy;

  // ****************************************
  // request decode and checks
  // ****************************************
  wire rx_fire = rx_valid_i && rx_ready_o;
  assign rx_ready_o = (state == ST_RECV);

  wire is_get  = (cmd == CMD_RD_COIL) || (cmd == CMD_RD_HOLD) || (cmd == CMD_RD_INPUT);
  wire is_set  = (cmd == CMD_WR_COIL) || (cmd == CMD_WR_HOLD);
  wire is_coil = (cmd == CMD_RD_COIL) || (cmd == CMD_WR_COIL);
  wire set_ok  = is_set && !err;

  // eight coils to a byte, 16-bit words two bytes each
  wire [16:0] coil_bytes = ({1'b0, reg_cnt} + 17'd7) >> 3;
  wire [16:0] word_bytes = {reg_cnt, 1'b0};
  wire [16:0] exp_bytes  = is_coil ? coil_bytes : word_bytes;
  wire [8:0]  exp_frame  = is_get ? {1'b0, GET_FRAME_LEN}
                                  : {1'b0, SET_HDR_LEN} + {1'b0, byte_cnt};

  wire frame_bad = overflow || ({1'b0, rx_idx} != exp_frame);
  wire count_bad = (reg_cnt == 16'h0000) || (exp_bytes > 17'(MAX_DATA));
  wire bcnt_bad  = is_set && ({9'h000, byte_cnt} != exp_bytes);
  wire range_bad = ({1'b0, start_addr} + {1'b0, reg_cnt}) > ADDR_LIMIT;

  wire [7:0] check_exc = (!is_get && !is_set) ? EXC_ILL_FUNC :
                         (frame_bad || count_bad || bcnt_bad) ? EXC_ILL_VALUE :
                         range_bad ? EXC_ILL_ADDR : EXC_NONE;

  // ****************************************
  // register access
  // ****************************************
  wire          last_op    = (op_idx == reg_cnt - 16'h0001);
  wire [DW-1:0] word_idx   = {op_idx[DW-2:0], 1'b0};
  wire [DW-1:0] word_idx_lo = word_idx + 1'b1;
  wire [DW-1:0] coil_idx   = op_idx[DW+2:3];
  wire [7:0]    coil_byte  = wmem[coil_idx];
  wire          coil_bit   = coil_byte[op_idx[2:0]];
  wire [15:0]   next_wdata = is_coil ? {15'h0000, coil_bit}
                                     : {wmem[word_idx], wmem[word_idx_lo]};
  wire iocr_kind_t kind_sel = is_coil ? KIND_COIL :
                              (cmd == CMD_RD_INPUT) ? KIND_INPUT : KIND_HOLD;
  wire ack_ok = reg_ack_i && !reg_bad_addr_i && !reg_fault_i;

  assign reg_req_o = (state == ST_WAIT);

  // ****************************************
  // response assembly
  // ****************************************
  wire [7:0]    acc_next   = acc | ({7'h00, reg_rdata_i[0]} << op_idx[2:0]);
  wire          coil_flush = (op_idx[2:0] == 3'h7) || last_op;
  wire          data_we    = (state == ST_WAIT) && ack_ok && is_get
                             && (!is_coil || coil_flush);
  wire [IW-1:0] data_idx   = (is_coil ? IW'(coil_idx) : IW'(word_idx))
                             + IW'(RSP_DATA_POS);

  wire        hdr_last  = set_ok ? (hdr_step == 2'd2) : (hdr_step == 2'd0);
  wire [15:0] hdr_wdata = err ? {cmd | ERR_FLAG, exc} :
                          !is_set ? {cmd, exp_bytes[7:0]} :
                          (hdr_step == 2'd0) ? {cmd, start_addr[15:8]} :
                          (hdr_step == 2'd1) ? {start_addr[7:0], reg_cnt[15:8]} :
                          {8'h00, reg_cnt[7:0]};
  wire          hdr_two = !(set_ok && (hdr_step == 2'd2));
  wire [IW-1:0] hdr_idx = IW'({hdr_step, 1'b0});
  wire [IW-1:0] rsp_len = err ? IW'(ERR_RSP_LEN) : is_set ? IW'(SET_RSP_LEN)
                          : IW'(RSP_DATA_POS) + IW'(exp_bytes[7:0]);

  wire          in_hdr    = (state == ST_HDR);
  wire          buf_we    = in_hdr || data_we;
  wire          buf_two   = in_hdr ? hdr_two : !is_coil;
  wire [IW-1:0] buf_idx   = in_hdr ? hdr_idx : data_idx;
  wire [15:0]   buf_wdata = in_hdr ? hdr_wdata
                            : is_coil ? {8'h00, acc_next} : reg_rdata_i;
  wire          buf_start = (state == ST_LAUNCH);

  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RECV:   if (rx_fire && rx_last_i) next_state = ST_CHECK;
      ST_CHECK:  next_state = (check_exc != EXC_NONE) ? ST_HDR : ST_ISSUE;
      ST_ISSUE:  next_state = ST_WAIT;
      ST_WAIT:   if (reg_ack_i) next_state = (!ack_ok || last_op) ? ST_HDR : ST_ISSUE;
      ST_HDR:    if (hdr_last) next_state = ST_LAUNCH;
      ST_LAUNCH: next_state = ST_SEND;
      ST_SEND:   if (!buf_busy) next_state = ST_RECV;
      default:   next_state = ST_RECV;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      state <= ST_RECV;
    else
      state <= next_state;
  end

  // a partial set that fails midway leaves earlier registers written
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      op_idx   <= 16'h0000;
      acc      <= 8'h00;
      err      <= 1'b0;
      exc      <= EXC_NONE;
      hdr_step <= 2'd0;
    end
    else if (state == ST_CHECK)
    begin
      op_idx   <= 16'h0000;
      acc      <= 8'h00;
      hdr_step <= 2'd0;
      err      <= (check_exc != EXC_NONE);
      exc      <= check_exc;
    end
    else if (state == ST_WAIT && reg_ack_i && reg_bad_addr_i)
    begin
      err <= 1'b1;
      exc <= EXC_ILL_ADDR;
    end
    else if (state == ST_WAIT && reg_ack_i && reg_fault_i)
    begin
      err <= 1'b1;
      exc <= EXC_DEV_FAIL;
    end
    else if (state == ST_WAIT && reg_ack_i)
    begin
      op_idx <= op_idx + 16'h0001;
      acc    <= coil_flush ? 8'h00 : acc_next;
    end
    else if (in_hdr)
      hdr_step <= hdr_step + 2'd1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_addr_o  <= 16'h0000;
      reg_wdata_o <= 16'h0000;
      reg_we_o    <= 1'b0;
      reg_kind_o  <= KIND_COIL;
    end
    else if (state == ST_ISSUE)
    begin
      reg_addr_o  <= start_addr + op_idx;
      reg_wdata_o <= next_wdata;
      reg_we_o    <= is_set;
      reg_kind_o  <= kind_sel;
    end
  end

  // ****************************************
  // request capture
  // ****************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_idx     <= 8'h00;
      overflow   <= 1'b0;
      cmd        <= 8'h00;
      start_addr <= 16'h0000;
      reg_cnt    <= 16'h0000;
      byte_cnt   <= 8'h00;
    end
    else if (state == ST_SEND && !buf_busy)
    begin
      rx_idx   <= 8'h00;
      overflow <= 1'b0;
    end
    else if (rx_fire)
    begin
      if (rx_idx == RX_LIMIT)
        overflow <= 1'b1;
      else
        rx_idx <= rx_idx + 8'h01;
      if (rx_idx == POS_CMD)
        cmd <= rx_data_i;
      else if (rx_idx == POS_ADDR_HI)
        start_addr[15:8] <= rx_data_i;
      else if (rx_idx == POS_ADDR_LO)
        start_addr[7:0] <= rx_data_i;
      else if (rx_idx == POS_CNT_HI)
        reg_cnt[15:8] <= rx_data_i;
      else if (rx_idx == POS_CNT_LO)
        reg_cnt[7:0] <= rx_data_i;
      else if (rx_idx == POS_BCNT)
        byte_cnt <= rx_data_i;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (rx_fire && rx_idx >= SET_HDR_LEN && rx_idx < RX_LIMIT)
      wmem[DW'(rx_idx - SET_HDR_LEN)] <= rx_data_i;
  end

  // ****************************************
  // submodules
  // ****************************************
  iocr_rsp_buf #(
    .DEPTH (2 * MAX_DATA),
    .IDX_W (IW)
  ) u_rsp_buf (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_en_i    (buf_we),
    .wr_two_i   (buf_two),
    .wr_idx_i   (buf_idx),
    .wr_data_i  (buf_wdata),
    .start_i    (buf_start),
    .len_i      (rsp_len),
    .busy_o     (buf_busy),
    .tx_ready_i (tx_ready_i),
    .tx_valid_o (tx_valid_o),
    .tx_data_o  (tx_data_o)
  );

  // clear events sit nine codes above their triggers
  wire [TRAP_COUNT-1:0] trap_evt = {level_clear_i, pin_clear_i, sensor_clear_i,
                                    level_alarm_i, pin_alarm_i, sensor_alarm_i};

  iocr_trap_enc #(
    .CHAN_W (CHAN_W)
  ) u_trap_enc (
    .ref_clk_i    (ref_clk_i),
    .sys_rst_i    (sys_rst_i),
    .evt_i        (trap_evt),
    .evt_chan_i   (alarm_chan_i),
    .trap_ready_i (trap_ready_i),
    .trap_valid_o (trap_valid_o),
    .trap_code_o  (trap_code_o),
    .trap_chan_o  (trap_chan_o)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_req_hold: assert property (
    (reg_req_o && !reg_ack_i) |=> (reg_req_o && $stable(reg_addr_o) && $stable(reg_wdata_o)))
    else $error("register access changed before its answer");

  a_addr_step: assert property (
    (state == ST_WAIT && ack_ok && !last_op) |=> ##1
      (reg_req_o && reg_addr_o == $past(reg_addr_o, 2) + 16'h0001))
    else $error("next register address is not consecutive");

  a_ill_func: assert property (
    (state == ST_CHECK && check_exc == EXC_ILL_FUNC) |=> ##2
      (tx_valid_o && tx_data_o == (cmd | ERR_FLAG) && exc == EXC_ILL_FUNC))
    else $error("bad command not answered with flagged code and error 01");

  a_bad_addr: assert property (
    (state == ST_WAIT && reg_ack_i && reg_bad_addr_i) |=>
      (state == ST_HDR && err && exc == EXC_ILL_ADDR))
    else $error("refused address not reported as error 02");

  a_dev_fail: assert property (
    (state == ST_WAIT && reg_ack_i && !reg_bad_addr_i && reg_fault_i) |=>
      (state == ST_HDR && err && exc == EXC_DEV_FAIL))
    else $error("register fault not reported as error 04");

  a_bcnt_check: assert property (
    (state == ST_CHECK && is_set && bcnt_bad && check_exc != EXC_ILL_FUNC) |=>
      (err && exc == EXC_ILL_VALUE))
    else $error("byte count mismatch not reported as error 03");

  a_coil_pack: assert property (
    (state == ST_CHECK && is_coil && reg_cnt == 16'h0002) |-> (exp_bytes == 17'h00001))
    else $error("two coils do not pack into one byte");

  a_coil_bit: assert property (
    (reg_req_o && reg_we_o && reg_kind_o == KIND_COIL) |-> (reg_wdata_o[0] == coil_bit))
    else $error("coil write bit not taken from the bit field");

  a_word_order: assert property (
    (reg_req_o && reg_we_o && reg_kind_o == KIND_HOLD) |->
      (reg_wdata_o == {wmem[word_idx], wmem[word_idx_lo]}))
    else $error("holding write not most significant byte first");

  c_get_ok: cover property (state == ST_LAUNCH && !err && is_get);
  c_set_ok: cover property (state == ST_LAUNCH && set_ok);
  c_error:  cover property (state == ST_LAUNCH && err);

endmodule

// ---- core/iocr_trap_enc.sv ----
// alarm event to trap encoder
// assumes events are one-cycle pulses from logic on the same clock
`timescale 1ns/10ps
module iocr_trap_enc #(
  parameter int CHAN_W = 4
) (
  // clock and reset
  input  wire logic                            ref_clk_i,
  input  wire logic                            sys_rst_i,
  // events, bit index is the trap code
  input  wire logic [iocr_pkg::TRAP_COUNT-1:0] evt_i,
  input  wire logic [CHAN_W-1:0]               evt_chan_i,
  // trap output
  input  wire logic                            trap_ready_i,
  output logic                                 trap_valid_o,
  output logic [4:0]                           trap_code_o,
  output logic [CHAN_W-1:0]                    trap_chan_o
);
  import iocr_pkg::*;

  localparam int N = TRAP_COUNT;

  logic [N-1:0]      pending;
  logic [CHAN_W-1:0] chan_mem [N];
  logic [4:0]        pick;
  logic              found;

  // lowest code first
  always_comb
  begin
    pick  = 5'h00;
    found = 1'b0;
    for (int i = N - 1; i >= 0; i--)
      if (pending[i])
      begin
        pick  = 5'(i);
        found = 1'b1;
      end
  end

  wire         launch = found && (!trap_valid_o || trap_ready_i);
  wire [N-1:0] served = launch ? ({{(N-1){1'b0}}, 1'b1} << pick) : '0;

  // a repeat of a still pending code merges with it; set wins over serve
  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      pending <= '0;
    else
      pending <= (pending & ~served) | evt_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    for (int i = 0; i < N; i++)
      if (evt_i[i])
        chan_mem[i] <= evt_chan_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      trap_valid_o <= 1'b0;
      trap_code_o  <= 5'h00;
      trap_chan_o  <= '0;
    end
    else if (launch)
    begin
      trap_valid_o <= 1'b1;
      trap_code_o  <= pick;
      trap_chan_o  <= chan_mem[pick];
    end
    else if (trap_ready_i)
      trap_valid_o <= 1'b0;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_trap_first: assert property (
    (pending == '0 && !trap_valid_o && evt_i[0]) |=> ##1
      (trap_valid_o && trap_code_o == 5'h00 && trap_chan_o == $past(evt_chan_i, 2)))
    else $error("sensor alarm did not give trap zero with its channel");

  a_trap_hold: assert property (
    (trap_valid_o && !trap_ready_i) |=> (trap_valid_o && $stable(trap_code_o)))
    else $error("trap dropped or changed while stalled");

  c_trap_clear: cover property (trap_valid_o && trap_code_o >= 5'(TRAP_CLEAR_BASE));

endmodule

// ---- verif/iocr_reg_model.sv ----
// channel register space model facing the command responder
// answers each access in its request cycle; refuses 0xFFF0, faults 0xEEE0
`timescale 1ns/10ps
module iocr_reg_model (
  // access from the responder
  input  wire logic                 ref_clk_i,
  input  wire logic                 reg_req_o,
  input  wire iocr_pkg::iocr_kind_t reg_kind_o,
  input  wire logic [15:0]          reg_addr_o,
  // answer
  output logic                      reg_ack_i,
  output logic [15:0]               reg_rdata_i,
  output logic                      reg_bad_addr_i,
  output logic                      reg_fault_i
);
  import iocr_pkg::*;
  // ****************************************
  // answers
  // ****************************************
  // between accesses the data bus wanders, so a stale read cannot pass
  logic [15:0] idle_pat = 16'hA5C3;
  always @(posedge ref_clk_i) idle_pat <= ~idle_pat + 16'h0001;
  assign reg_ack_i      = reg_req_o;
  assign reg_bad_addr_i = reg_req_o && reg_addr_o == 16'hFFF0;
  assign reg_fault_i    = reg_req_o && reg_addr_o == 16'hEEE0;
  assign reg_rdata_i    = !reg_req_o ? idle_pat :
                          reg_kind_o == KIND_COIL ? {15'h0000, reg_addr_o[0]} :
                          {reg_addr_o[7:0], reg_addr_o[15:8]};
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the command responder top
// assumes the register model answers every access at once
`timescale 1ns/10ps
module tb;
  import iocr_pkg::*;
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, rx_valid_i = 1'b0, rx_last_i = 1'b0;
  logic tx_ready_i = 1'b1, trap_ready_i = 1'b1, sensor_alarm_i = 1'b0, sensor_clear_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00, tx_data_o;
  logic rx_ready_o, tx_valid_o, reg_req_o, reg_we_o, reg_ack_i, reg_bad_addr_i;
  logic reg_fault_i, trap_valid_o;
  iocr_kind_t reg_kind_o;
  logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [2:0] pin_alarm_i = 3'h0, pin_clear_i = 3'h0;
  logic [4:0] level_alarm_i = 5'h00, level_clear_i = 5'h00, trap_code_o;
  logic [3:0] alarm_chan_i = 4'h0, trap_chan_o;
  logic [15:0] wq[$];
  int failures = 0, n_tests = 0, cyc = 0;
  iocr_top dut (.*);
  iocr_reg_model model (.*);
  // ****************************************
  // clock, watchdog, write capture
  // ****************************************
  initial forever #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (reg_req_o && reg_ack_i && reg_we_o) wq.push_back(reg_wdata_o);
    if (cyc == 3000)
    begin
      failures++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xact(string what, input logic [7:0] rq[$], input logic [7:0] rs[$]);
    int i;
    int t;
    for (i = 0; i < rq.size(); i++)
    begin
      @(negedge ref_clk_i);
      rx_valid_i = 1'b1;
      rx_data_i = rq[i];
      rx_last_i = (i == rq.size() - 1);
      @(posedge ref_clk_i);
      while (rx_ready_o !== 1'b1) @(posedge ref_clk_i);
    end
    @(negedge ref_clk_i);
    rx_valid_i = 1'b0;
    rx_last_i = 1'b0;
    // sampled at the falling edge, where each response byte is settled
    for (i = 0; i < rs.size(); i++)
    begin
      t = 0;
      @(negedge ref_clk_i);
      while (tx_valid_o !== 1'b1 && t < 60)
      begin
        t++;
        @(negedge ref_clk_i);
      end
      chk(what, rs[i], tx_data_o);
      if (i == 0)
      begin
        // one stalled cycle: the first byte must still stand
        tx_ready_i = 1'b0;
        @(negedge ref_clk_i);
        chk(what, rs[0], tx_data_o);
        tx_ready_i = 1'b1;
      end
    end
  endtask
  task automatic trap_wait(logic [7:0] code, logic [7:0] chan);
    int t;
    t = 0;
    while (trap_valid_o !== 1'b1 && t < 10)
    begin
      @(negedge ref_clk_i);
      t++;
    end
    chk("trap code", code, {3'h0, trap_code_o});
    chk("trap chan", chan, {4'h0, trap_chan_o});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_set_coil;
    wq.delete();
    xact("set coil", '{8'h0F, 8'h1A, 8'h03, 8'h00, 8'h02, 8'h01, 8'h01},
         '{8'h0F, 8'h1A, 8'h03, 8'h00, 8'h02});
    chk("coil bits", 8'h01, {6'h00, wq[1][0], wq[0][0]});
  endtask
  task automatic t_set_hold;
    wq.delete();
    xact("set hold", '{8'h10, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02, 8'h12, 8'h34},
         '{8'h10, 8'h00, 8'h20, 8'h00, 8'h01});
    chk("hold word", 8'h12, wq[0][15:8]);
  endtask
  task automatic t_trap;
    @(negedge ref_clk_i);
    alarm_chan_i = 4'h5;
    level_clear_i = 5'h10;
    @(negedge ref_clk_i);
    level_clear_i = 5'h00;
    trap_wait(8'h11, 8'h05);
    alarm_chan_i = 4'h9;
    pin_alarm_i = 3'h2;
    @(negedge ref_clk_i);
    pin_alarm_i = 3'h0;
    trap_wait(8'h02, 8'h09);
  endtask
  initial
  begin
    repeat (4) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    xact("get hold", '{8'h03, 8'h18, 8'h42, 8'h00, 8'h02},
         '{8'h03, 8'h04, 8'h42, 8'h18, 8'h43, 8'h18});
    xact("get coil", '{8'h01, 8'h00, 8'h10, 8'h00, 8'h02}, '{8'h01, 8'h01, 8'h02});
    xact("get input", '{8'h04, 8'h08, 8'h86, 8'h00, 8'h01}, '{8'h04, 8'h02, 8'h86, 8'h08});
    t_set_coil;
    t_set_hold;
    xact("bad count", '{8'h10, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'hAA},
         '{8'h90, 8'h03});
    xact("bad cmd", '{8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'h85, 8'h01});
    xact("bad addr", '{8'h03, 8'hFF, 8'hF0, 8'h00, 8'h01}, '{8'h83, 8'h02});
    xact("fault", '{8'h04, 8'hEE, 8'hE0, 8'h00, 8'h01}, '{8'h84, 8'h04});
    t_trap;
    final_report;
  end
endmodule
